// >>> src/scu_cfg.svh
// Register offsets, field positions, reset values and timing counts of the smart-card channel
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SCU_OFF_MODE     12'h000
`define SCU_OFF_CTRL     12'h004
`define SCU_OFF_DIV      12'h008
`define SCU_OFF_TXBUF    12'h00C
`define SCU_OFF_RXBUF    12'h010
`define SCU_OFF_STAT     12'h014
`define SCU_OFF_IRQ_ST   12'h018
`define SCU_OFF_IRQ_EN   12'h01C
`define SCU_OFF_IRQ_CLR  12'h020

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define SCU_MODE_LSB     0
`define SCU_CKSRC_BIT    3
`define SCU_STOPS_BIT    4
`define SCU_PODD_BIT     5
`define SCU_PON_BIT      6
`define SCU_ORDER_BIT    7
`define SCU_INV_BIT      8
`define SCU_PRE_LSB      9
`define SCU_MODE_SIM     3'b101
`define SCU_MODE_RST     32'h0000_0000

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SCU_TE_BIT       0
`define SCU_RE_BIT       1
`define SCU_IRS_BIT      2
`define SCU_ERE_BIT      3

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define SCU_ST_TBE       0
`define SCU_ST_RXF       1
`define SCU_ST_OVR       2
`define SCU_ST_FRM       3
`define SCU_ST_PAR       4
`define SCU_ST_SUM       5
`define SCU_ST_TXIDLE    6
`define SCU_ST_RXLVL     7

// ---------------------------------------------------------------
// Interrupt bits
// ---------------------------------------------------------------
`define SCU_IRQ_TX       0
`define SCU_IRQ_RX       1
`define SCU_IRQ_ERR      2
`define SCU_IRQ_W        3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SCU_OVS          16
`define SCU_OVS_MID      4'h7
`define SCU_FRAME_BITS   4'hB

`endif

// >>> src/scu_pkg.sv
// Types shared by the smart-card channel
package scu_pkg;
	typedef enum logic [1:0] {SCU_TX_IDLE, SCU_TX_SHIFT, SCU_TX_DONE} scu_tx_type;
	typedef enum logic [1:0] {SCU_RX_IDLE, SCU_RX_SHIFT, SCU_RX_ERRSIG} scu_rx_type;

	typedef struct packed {
		logic        hsel_d;
		logic        hwrite_d;
		logic [11:0] haddr_d;
		logic [31:0] hrdata;
		logic [11:0] mode;
		logic [3:0]  ctrl;
		logic [7:0]  div;
		logic [7:0]  txbuf;
		logic        tbe;
		logic [7:0]  rxbuf;
		logic        rxf;
		logic        ovr;
		logic        frm;
		logic        par;
		logic [2:0]  irq_st;
		logic [2:0]  irq_en;
		logic        irq;
		logic [2:0]  rx_s;
		logic [2:0]  ck_s;
		logic [7:0]  pre_cnt;
		logic [7:0]  div_cnt;
		logic        tick;
		scu_tx_type  tx_st;
		logic [3:0]  tx_ph;
		logic [3:0]  tx_bit;
		logic [9:0]  tx_sh;
		logic        tx_low;
		scu_rx_type  rx_st;
		logic [3:0]  rx_ph;
		logic [3:0]  rx_bit;
		logic [9:0]  rx_sh;
		logic        sig_low;
		logic        oe;
	} scu_state_type;
endpackage

// >>> src/scu_uart.sv
// Smart-card compatible serial channel with AHB-Lite register slave
//
// Notes on behaviour
// - Bit clock is selected source, the internal one prescaled, divided by 16 times divisor plus one.
// - Transmit starts only with transmit enable set and buffer holding data.
// - Receive starts only with receive enable set and a start bit seen.
// - With source select set, transmit interrupt when character fully shifted out.
// - Receive interrupt when character moves into receive buffer.
// - Overrun when last data/parity bit arrives and buffer unread; no receive interrupt.
// - Framing error when the stop bit is not found.
// - Framing and parity flags update when character enters the buffer.
// - Error sum is set while any overrun, framing or parity error stands.
// - With error signal enabled, parity error pulls transmit line low.
// - Reading receive buffer during error signal clears parity flag, releases line.
// - Transmit-finished request follows the stop bit; software samples receive line.
// - Card pulls line low on parity error; receive level readable at that point.
// - Setting source select and error enable after reset raises a transmit request.
// - Direct format sends LSB first, even parity, true data.
// - Inverse format sends inverted data MSB first with odd parity.
// - Inverse format receive inverts, stores MSB first, checks odd parity.
// - Transmit line is open-drain; only ever driven low.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "scu_cfg.svh"

module scu_uart
	import scu_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        RX_LINE,
	input  wire logic        EXT_CLOCK_PIN,
	output logic             TX_LINE_O,
	output logic             TX_LINE_OE,
	output logic             IRQ
);

	scu_state_type s_r;
	scu_state_type s_nxt;

	logic addr_ok;
	logic wr;
	logic rd_rx;
	logic sim_on;
	logic ext_rise;
	logic rx_lvl;
	logic par_calc;
	logic [7:0] data_o;
	logic [2:0] ev;

	always_comb begin
		s_nxt = s_r;
		ev = 3'b000;
		// ---------------------------------------------------------------
		// Bus slave, zero wait states
		// ---------------------------------------------------------------
		addr_ok = HSEL && HREADY && HTRANS[1];
		s_nxt.hsel_d = addr_ok;
		s_nxt.hwrite_d = HWRITE;
		s_nxt.haddr_d = HADDR[11:0];
		wr = s_r.hsel_d && s_r.hwrite_d;
		rd_rx = addr_ok && !HWRITE && HADDR[11:0] == `SCU_OFF_RXBUF;
		s_nxt.hrdata = 32'h0000_0000;
		if (addr_ok && !HWRITE) begin
			case (HADDR[11:0])
				`SCU_OFF_MODE:   s_nxt.hrdata = {20'h0_0000, s_r.mode};
				`SCU_OFF_CTRL:   s_nxt.hrdata = {28'h000_0000, s_r.ctrl};
				`SCU_OFF_DIV:    s_nxt.hrdata = {24'h00_0000, s_r.div};
				`SCU_OFF_TXBUF:  s_nxt.hrdata = {24'h00_0000, s_r.txbuf};
				`SCU_OFF_RXBUF:  s_nxt.hrdata = {24'h00_0000, s_r.rxbuf};
				`SCU_OFF_STAT:   s_nxt.hrdata = {24'h00_0000, s_r.rx_s[2],
					s_r.tx_st == SCU_TX_IDLE, s_r.ovr | s_r.frm | s_r.par,
					s_r.par, s_r.frm, s_r.ovr, s_r.rxf, s_r.tbe};
				`SCU_OFF_IRQ_ST: s_nxt.hrdata = {29'h0000_0000, s_r.irq_st};
				`SCU_OFF_IRQ_EN: s_nxt.hrdata = {29'h0000_0000, s_r.irq_en};
				default:         s_nxt.hrdata = 32'h0000_0000;
			endcase
		end
		// Reading the buffer frees it and clears overrun and framing; parity only during the error signal
		if (rd_rx) begin
			s_nxt.rxf = 1'b0;
			s_nxt.ovr = 1'b0;
			s_nxt.frm = 1'b0;
			if (s_r.rx_st == SCU_RX_ERRSIG) begin
				s_nxt.par = 1'b0;
				s_nxt.sig_low = 1'b0;
				s_nxt.rx_st = SCU_RX_IDLE;
			end
		end
		if (wr) begin
			case (s_r.haddr_d)
				`SCU_OFF_MODE: s_nxt.mode = HWDATA[11:0];
				`SCU_OFF_CTRL: begin
					s_nxt.ctrl = HWDATA[3:0];
					// Request raised when both bits become set
					if (HWDATA[`SCU_IRS_BIT] && HWDATA[`SCU_ERE_BIT] &&
						!(s_r.ctrl[`SCU_IRS_BIT] && s_r.ctrl[`SCU_ERE_BIT]))
						ev[`SCU_IRQ_TX] = 1'b1;
				end
				`SCU_OFF_DIV: s_nxt.div = HWDATA[7:0];
				`SCU_OFF_TXBUF: begin
					s_nxt.txbuf = HWDATA[7:0];
					s_nxt.tbe = 1'b0;
				end
				`SCU_OFF_IRQ_EN: s_nxt.irq_en = HWDATA[2:0];
				`SCU_OFF_IRQ_CLR: s_nxt.irq_st = s_r.irq_st & ~HWDATA[2:0];
				default: ;
			endcase
		end
		sim_on = s_r.mode[`SCU_MODE_LSB +: 3] == `SCU_MODE_SIM;
		// ---------------------------------------------------------------
		// Bit clock: prescale the internal source (external edges are not prescaled), then divide by n+1 to the 16x tick
		// ---------------------------------------------------------------
		s_nxt.rx_s = {s_r.rx_s[1:0], RX_LINE};
		s_nxt.ck_s = {s_r.ck_s[1:0], EXT_CLOCK_PIN};
		rx_lvl = s_r.rx_s[2];
		ext_rise = s_r.ck_s[1] && !s_r.ck_s[2];
		s_nxt.tick = 1'b0;
		if (s_r.mode[`SCU_CKSRC_BIT]) begin
			s_nxt.pre_cnt = 8'h00;
			if (ext_rise) begin
				s_nxt.div_cnt = s_r.div_cnt - 8'h01;
				if (s_r.div_cnt == 8'h00) begin
					s_nxt.div_cnt = s_r.div;
					s_nxt.tick = 1'b1;
				end
			end
		end else begin
			s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
			// Prescale 1, 2, 8 or 32 from a two-bit field
			if ((s_r.mode[`SCU_PRE_LSB +: 2] == 2'd0) ||
				(s_r.mode[`SCU_PRE_LSB +: 2] == 2'd1 && s_r.pre_cnt[0]) ||
				(s_r.mode[`SCU_PRE_LSB +: 2] == 2'd2 && &s_r.pre_cnt[2:0]) ||
				(s_r.mode[`SCU_PRE_LSB +: 2] == 2'd3 && &s_r.pre_cnt[4:0])) begin
				s_nxt.div_cnt = s_r.div_cnt - 8'h01;
				if (s_r.div_cnt == 8'h00) begin
					s_nxt.div_cnt = s_r.div;
					s_nxt.tick = 1'b1;
				end
			end
		end
		// ---------------------------------------------------------------
		// Transmitter: start, 8 data, parity, stop
		// ---------------------------------------------------------------
		data_o = s_r.mode[`SCU_INV_BIT] ? ~s_r.txbuf : s_r.txbuf;
		if (s_r.mode[`SCU_ORDER_BIT])
			data_o = {data_o[0], data_o[1], data_o[2], data_o[3],
				data_o[4], data_o[5], data_o[6], data_o[7]};
		par_calc = ^data_o ^ s_r.mode[`SCU_PODD_BIT] ^ 1'b1;
		case (s_r.tx_st)
			SCU_TX_IDLE: begin
				s_nxt.tx_low = 1'b0;
				if (sim_on && s_r.tick && s_r.ctrl[`SCU_TE_BIT] && !s_r.tbe) begin
					s_nxt.tx_sh = {1'b1, par_calc, data_o};
					s_nxt.tbe = 1'b1;
					s_nxt.tx_low = 1'b1;
					s_nxt.tx_ph = 4'h0;
					s_nxt.tx_bit = 4'h0;
					s_nxt.tx_st = SCU_TX_SHIFT;
				end
			end
			SCU_TX_SHIFT: if (s_r.tick) begin
				s_nxt.tx_ph = s_r.tx_ph + 4'h1;
				if (s_r.tx_ph == 4'hF) begin
					s_nxt.tx_bit = s_r.tx_bit + 4'h1;
					s_nxt.tx_low = !s_r.tx_sh[0];
					s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
					if (s_r.tx_bit == 4'hA)
						s_nxt.tx_st = SCU_TX_DONE;
				end
			end
			SCU_TX_DONE: begin
				// Stop bit over: rx line now shows the card's verdict
				s_nxt.tx_low = 1'b0;
				if (s_r.ctrl[`SCU_IRS_BIT])
					ev[`SCU_IRQ_TX] = 1'b1;
				s_nxt.tx_st = SCU_TX_IDLE;
			end
			default: s_nxt.tx_st = SCU_TX_IDLE;
		endcase
		// ---------------------------------------------------------------
		// Receiver
		// ---------------------------------------------------------------
		case (s_r.rx_st)
			SCU_RX_IDLE: begin
				if (sim_on && s_r.tick && s_r.ctrl[`SCU_RE_BIT] && !rx_lvl) begin
					s_nxt.rx_ph = 4'h0;
					s_nxt.rx_bit = 4'h0;
					s_nxt.rx_st = SCU_RX_SHIFT;
				end
			end
			SCU_RX_SHIFT: if (s_r.tick) begin
				s_nxt.rx_ph = s_r.rx_ph + 4'h1;
				if (s_r.rx_ph == `SCU_OVS_MID) begin
					s_nxt.rx_bit = s_r.rx_bit + 4'h1;
					s_nxt.rx_sh = {rx_lvl, s_r.rx_sh[9:1]};
					if (s_r.rx_bit == 4'h0 && rx_lvl)
						s_nxt.rx_st = SCU_RX_IDLE; // False start
					if (s_r.rx_bit == 4'h9 && s_r.rxf) begin
						s_nxt.ovr = 1'b1;
						ev[`SCU_IRQ_ERR] = 1'b1;
					end
					if (s_r.rx_bit == 4'hA) begin
						s_nxt.rx_st = SCU_RX_IDLE;
						if (!s_nxt.ovr) begin
							// Start bit sits at the bottom, parity at the top
							s_nxt.rxbuf = s_r.mode[`SCU_INV_BIT] ? ~s_r.rx_sh[8:1] :
								s_r.rx_sh[8:1];
							if (s_r.mode[`SCU_ORDER_BIT])
								s_nxt.rxbuf = {s_nxt.rxbuf[0], s_nxt.rxbuf[1],
									s_nxt.rxbuf[2], s_nxt.rxbuf[3], s_nxt.rxbuf[4],
									s_nxt.rxbuf[5], s_nxt.rxbuf[6], s_nxt.rxbuf[7]};
							s_nxt.rxf = 1'b1;
							s_nxt.frm = !rx_lvl;
							s_nxt.par = ^s_r.rx_sh[9:1] ^ s_r.mode[`SCU_PODD_BIT] ^
								1'b1;
							ev[`SCU_IRQ_RX] = 1'b1;
							if (!rx_lvl || s_nxt.par)
								ev[`SCU_IRQ_ERR] = 1'b1;
							if (s_nxt.par && s_r.ctrl[`SCU_ERE_BIT]) begin
								s_nxt.sig_low = 1'b1;
								s_nxt.rx_st = SCU_RX_ERRSIG;
							end
						end
					end
				end
			end
			SCU_RX_ERRSIG: ; // Line held low until the buffer is read
			default: s_nxt.rx_st = SCU_RX_IDLE;
		endcase
		if (!sim_on) begin
			s_nxt.tx_st = SCU_TX_IDLE;
			s_nxt.tx_low = 1'b0;
		end
		// Pin enable registered on its own so the output comes from one flop
		s_nxt.oe = s_nxt.tx_low | s_nxt.sig_low;
		// ---------------------------------------------------------------
		// Interrupts: set wins over clear
		// ---------------------------------------------------------------
		s_nxt.irq_st = s_nxt.irq_st | ev;
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			s_r <= '0;
			s_r.tbe <= 1'b1;
			// Idle line is high; avoids a false start after reset
			s_r.rx_s <= 3'b111;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign HRDATA = s_r.hrdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	// Open drain: drive only low
	assign TX_LINE_O = 1'b0;
	assign TX_LINE_OE = s_r.oe;
	assign IRQ = s_r.irq;

endmodule // scu_uart

// >>> verification/scu_uart_assertions.sv
// Port-level checks of the smart-card channel
`timescale 1ns/10ps
module scu_uart_assertions (
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        TX_LINE_O,
	input wire logic        TX_LINE_OE,
	input wire logic        IRQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	logic       req;
	logic [3:0] wr_h;
	logic [2:0] rd_h;
	logic [8:0] lo_cnt;
	assign req = HSEL && HREADY && HTRANS[1];
	// ----
	// Recent writes, buffer reads, low-run length
	// ----
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wr_h   <= 4'h0;
			rd_h   <= 3'h0;
			lo_cnt <= 9'h000;
		end else begin
			wr_h   <= {wr_h[2:0], req && HWRITE};
			rd_h   <= {rd_h[1:0], req && !HWRITE && HADDR[11:0] == 12'h010};
			lo_cnt <= !TX_LINE_OE ? 9'h000 : (lo_cnt == 9'h1FF ? lo_cnt : lo_cnt + 9'h001);
		end
	end
	sequence rx_read;
		req && !HWRITE && HADDR[11:0] == 12'h010;
	endsequence
	sequence stat_read;
		req && !HWRITE && HADDR[11:0] == 12'h014;
	endsequence
	AST_OKAY: assert property (HREADYOUT && !HRESP)
		else $error("slave not ready or not okay");
	AST_OPEN_DRAIN: assert property (!TX_LINE_O)
		else $error("tx line driven high");
	AST_ERR_RELEASE: assert property (rx_read ##0 TX_LINE_OE |-> ##[1:3] !TX_LINE_OE)
		else $error("error signal kept after buffer read");
	// A bit never lasts under 16 ticks; a buffer read may cut the error signal short
	AST_BIT_MIN: assert property ($fell(TX_LINE_OE) && rd_h == 3'h0 |-> lo_cnt >= 9'h010)
		else $error("low level shorter than one bit");
	AST_IRQ_FALL: assert property ($fell(IRQ) |-> wr_h != 4'h0)
		else $error("interrupt dropped without a write");
	AST_STAT_SUM: assert property (stat_read |=> HRDATA[5] == (|HRDATA[4:2]))
		else $error("error sum disagrees with flags");
	AST_UNMAPPED: assert property (req && !HWRITE && HADDR[11:0] > 12'h020 |=> HRDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_STAT_RSVD: assert property (stat_read |=> HRDATA[31:8] == 24'h00_0000)
		else $error("status upper bits not zero");
endmodule // scu_uart_assertions

// >>> verification/scu_card_model.sv
// Behavioural card on the two open-drain lines of the channel
`timescale 1ns/10ps
module scu_card_model (
	input wire logic clk,
	input wire logic line_in,
	output logic     line_oe
);
	int bt;
	initial begin
		bt      = 16;
		line_oe = 1'b0; // Released, the pull-up gives high
	end
	// Mid-bit samples of a device frame, start bit first
	task automatic take(output logic [10:0] f);
		while (line_in !== 1'b0) @(posedge clk);
		repeat (bt / 2) @(posedge clk);
		for (int k = 0; k < 11; k++) begin
			f[k] = line_in;
			repeat (bt) @(posedge clk);
		end
	endtask
	// Low bits pull the line, high bits release it
	task automatic send(input logic [10:0] f);
		for (int k = 0; k < 11; k++) begin
			line_oe <= ~f[k];
			repeat (bt) @(posedge clk);
		end
		line_oe <= 1'b0;
		@(posedge clk);
	endtask
endmodule // scu_card_model

// >>> verification/test_smart_card_sim_uart_mode.sv
// Self-checking bench of the smart-card channel against a card model
`timescale 1ns/10ps
`include "scu_cfg.svh"
module test_smart_card_sim_uart_mode
	import scu_pkg::*;
;
	logic        CLK;
	logic        RESET;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA;
	logic        ext_clk;
	wire  [31:0] HRDATA;
	wire         HREADYOUT;
	wire         HRESP;
	wire         TX_LINE_O;
	wire         TX_LINE_OE;
	wire         IRQ;
	wire         card_oe;
	int          n_fail;
	int          samples_checked;
	int          cyc;
	int          seed;
	logic [31:0] rdat;
	logic [10:0] f;
	logic [7:0]  d;
	scu_uart scu_uart_i (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_LINE(~card_oe),
		.EXT_CLOCK_PIN(ext_clk), .TX_LINE_O(TX_LINE_O), .TX_LINE_OE(TX_LINE_OE), .IRQ(IRQ));
	scu_card_model scu_card_model_i (.clk(CLK), .line_in(~TX_LINE_OE), .line_oe(card_oe));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// Four CLK periods, edges offset from CLK
	initial begin
		ext_clk = 1'b0;
		forever #20 ext_clk = ~ext_clk;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			report_and_stop;
		end
	end
	// ----
	// Bus, compare and frame helpers
	// ----
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		HADDR  <= {20'h0_0000, a};
		HWRITE <= w;
		HTRANS <= 2'b10;
		HSEL   <= 1'b1;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'b00;
		HSEL   <= 1'b0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rdat = HRDATA;
	endtask
	task automatic chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		repeat (3) @(posedge CLK);
		bus(1'b0, a, 32'h0000_0000);
		cmp(32'(rdat[7:0] & m), 32'(e));
	endtask
	function automatic logic [10:0] frm(input logic [7:0] v, input logic inv, input logic bad_p,
		input logic bad_s);
		logic [7:0] t;
		for (int i = 0; i < 8; i++)
			t[i] = inv ? ~v[7 - i] : v[i];
		return {~bad_s, (inv ? ~^t : ^t) ^ bad_p, t, 1'b0};
	endfunction
	// ----
	// Main sequence
	// ----
	initial begin
		{HSEL, HADDR, HTRANS, HWRITE, HWDATA} = '0;
		HSIZE = 3'b010;
		RESET = 1'b1;
		seed = 95837;
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		chk(`SCU_OFF_MODE, 8'hFF, 8'h00);
		chk(12'h100, 8'hFF, 8'h00);
		bus(1'b1, `SCU_OFF_MODE, 32'h0000_0065);
		bus(1'b1, `SCU_OFF_CTRL, 32'h0000_000C);
		chk(`SCU_OFF_IRQ_ST, 8'h01, 8'h01);
		cmp(32'(IRQ), 32'h0000_0000);
		bus(1'b1, `SCU_OFF_IRQ_EN, 32'h0000_0007);
		chk(`SCU_OFF_IRQ_ST, 8'h01, 8'h01);
		cmp(32'(IRQ), 32'h0000_0001);
		bus(1'b1, `SCU_OFF_IRQ_CLR, 32'h0000_0007);
		chk(`SCU_OFF_IRQ_ST, 8'h07, 8'h00);
		cmp(32'(IRQ), 32'h0000_0000);
		// Direct with divisor 1, then inverse on the external clock
		for (int m = 0; m < 2; m++) begin
			scu_card_model_i.bt = 32 * (m + 1);
			bus(1'b1, `SCU_OFF_DIV, 32'(1 - m));
			bus(1'b1, `SCU_OFF_MODE, m ? 32'h0000_01CD : 32'h0000_0065);
			bus(1'b1, `SCU_OFF_CTRL, 32'h0000_000F);
			for (int k = 0; k < 3; k++) begin
				d = k ? 8'($random(seed)) : {8{m[0]}};
				bus(1'b1, `SCU_OFF_TXBUF, 32'(d));
				scu_card_model_i.take(f);
				cmp(32'(f), 32'(frm(d, m[0], 1'b0, 1'b0)));
				chk(`SCU_OFF_IRQ_ST, 8'h01, 8'h01);
				cmp(32'(IRQ), 32'h0000_0001);
				chk(`SCU_OFF_STAT, 8'h80, 8'h80);
				bus(1'b1, `SCU_OFF_IRQ_CLR, 32'h0000_0007);
				scu_card_model_i.send(frm(d, m[0], 1'b0, 1'b0));
				chk(`SCU_OFF_IRQ_ST, 8'h02, 8'h02);
				chk(`SCU_OFF_STAT, 8'h3E, 8'h02);
				chk(`SCU_OFF_RXBUF, 8'hFF, d);
				bus(1'b1, `SCU_OFF_IRQ_CLR, 32'h0000_0007);
			end
		end
		d = 8'($random(seed));
		scu_card_model_i.send(frm(d, 1'b1, 1'b1, 1'b0));
		cmp(32'(TX_LINE_OE), 32'h0000_0001);
		chk(`SCU_OFF_STAT, 8'h30, 8'h30);
		bus(1'b0, `SCU_OFF_RXBUF, 32'h0000_0000);
		chk(`SCU_OFF_STAT, 8'h10, 8'h00);
		cmp(32'(TX_LINE_OE), 32'h0000_0000);
		scu_card_model_i.send(frm(d, 1'b1, 1'b0, 1'b1));
		chk(`SCU_OFF_STAT, 8'h28, 8'h28);
		bus(1'b0, `SCU_OFF_RXBUF, 32'h0000_0000);
		bus(1'b1, `SCU_OFF_IRQ_CLR, 32'h0000_0007);
		scu_card_model_i.send(frm(d, 1'b1, 1'b0, 1'b0));
		bus(1'b1, `SCU_OFF_IRQ_CLR, 32'h0000_0007);
		scu_card_model_i.send(frm(~d, 1'b1, 1'b0, 1'b0));
		chk(`SCU_OFF_STAT, 8'h24, 8'h24);
		chk(`SCU_OFF_IRQ_ST, 8'h06, 8'h04);
		chk(`SCU_OFF_RXBUF, 8'hFF, d);
		// Both directions disabled: data waits, nothing is received
		bus(1'b1, `SCU_OFF_CTRL, 32'h0000_000C);
		bus(1'b1, `SCU_OFF_TXBUF, 32'h0000_005A);
		// Card holds the line low: the receive level must show it
		fork
			scu_card_model_i.send(frm(d, 1'b1, 1'b0, 1'b0));
			begin
				repeat (8) @(posedge CLK);
				chk(`SCU_OFF_STAT, 8'h80, 8'h00);
			end
		join
		cmp(32'(TX_LINE_OE), 32'h0000_0000);
		chk(`SCU_OFF_STAT, 8'h43, 8'h40);
		report_and_stop;
	end
endmodule // test_smart_card_sim_uart_mode

bind scu_uart scu_uart_assertions scu_uart_assertions_i (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_LINE_O(TX_LINE_O), .TX_LINE_OE(TX_LINE_OE),
	.IRQ(IRQ));
